// *** include/sss_pkg.sv ***
// Purpose: constants and types for the sample state statistics unit
// Assumes: one 125 MHz clock, registers on a plain strobe port
// Notes:
package sss_pkg;
	localparam int unsigned CLK_HZ       = 125000000;
	localparam int unsigned INTERVAL_MS  = 10;
	localparam int unsigned INTERVAL_CYC = CLK_HZ / 1000 * INTERVAL_MS;
	localparam int unsigned N_STREAMS    = 16;
	localparam int unsigned N_LAGS       = 64;
	localparam int unsigned N_BLOCKS     = 16;
	localparam int unsigned WINDOW_DIV   = 16;
	localparam int unsigned CW           = 32;
	// register indices
	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_WBSEL  = 8'h01;
	localparam logic [7:0] A_SBST   = 8'h02;
	localparam logic [7:0] A_PFREQ  = 8'h03;
	localparam logic [7:0] A_PDLY   = 8'h04;
	localparam logic [7:0] A_ACFSEL = 8'h05;
	localparam logic [7:0] A_STAT   = 8'h06;
	localparam logic [7:0] A_WBCNT  = 8'h10;
	localparam logic [7:0] A_WB8    = 8'h20;
	localparam logic [7:0] A_SBCNT  = 8'h21;
	localparam logic [7:0] A_PWRLO  = 8'h22;
	localparam logic [7:0] A_PWRHI  = 8'h23;
	localparam logic [7:0] A_PCI    = 8'h24;
	localparam logic [7:0] A_PCQ    = 8'h25;
	localparam logic [7:0] A_ACF    = 8'h40;
	localparam logic [6:0] SB4_LAST = 7'h0F;
	localparam logic [6:0] SB7_LAST = 7'h7F;

	typedef struct packed {
		logic       wb_8bit;
		logic       sb_7bit;
		logic       sb_step;
		logic [3:0] wb_base;
		logic [2:0] wb_lane;
		logic [7:0] wb_state;
		logic [1:0] acf_prod;
		logic [3:0] acf_block;
	} sss_cfg_t;

	localparam sss_cfg_t CFG_RST = '0;

	typedef struct packed {
		logic       valid;
		logic       first;
		logic [3:0] data;
	} sss_sb_t;
endpackage : sss_pkg

// *** src/sss_pcal.sv ***
// Purpose: phase-cal tone extractor on the re-quantized stream
// Assumes: sample arrives signed, one per valid cycle
// Notes: square-wave local oscillator; cheap, adds odd-harmonic pickup
`timescale 1ns/100ps
`default_nettype none
module sss_pcal
	import sss_pkg::*;
(
	// clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// sample stream
	input  wire logic                valid,
	input  wire logic signed [7:0]   sample,
	input  wire logic                restart,
	// synthesizer
	input  wire logic [31:0]         freq,
	input  wire logic [31:0]         delay_phase,
	// results
	output logic signed [CW-1:0]     acc_i,
	output logic signed [CW-1:0]     acc_q
);
	logic [31:0]            phase_reg;
	logic [31:0]            lo_phase;
	logic signed [CW-1:0]   s_ext;
	logic signed [CW-1:0]   ci;
	logic signed [CW-1:0]   cq;

	// delay tracking shifts the oscillator phase, not the data
	assign lo_phase = phase_reg + delay_phase;
	assign s_ext    = CW'(sample);
	assign ci = !valid ? '0 : (lo_phase[31] ^ lo_phase[30]) ? -s_ext : s_ext;
	assign cq = !valid ? '0 : lo_phase[31] ? s_ext : -s_ext;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			phase_reg <= '0;
		else if (valid)
			phase_reg <= phase_reg + freq;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			acc_i <= '0;
			acc_q <= '0;
		end else if (restart) begin
			acc_i <= ci;
			acc_q <= cq;
		end else begin
			acc_i <= acc_i + ci;
			acc_q <= acc_q + cq;
		end
	end
endmodule : sss_pcal
`default_nettype wire

// *** src/sss_top.sv ***
// Purpose: wideband and sub-band sample statistics, power, phase-cal, coarse auto-correlation
// Assumes: highway and sub-band inputs synchronous to ref_clk
// Notes: multiplexing settings written by the board_monitor_computer take effect at interval end; phase-cal and sub-band state writes act at once
`timescale 1ns/100ps
`default_nettype none
module sss_top
	import sss_pkg::*;
#(
	parameter int unsigned INTERVAL = INTERVAL_CYC,
	parameter int unsigned RING     = N_LAGS * N_BLOCKS
)(
	// clock and reset
	input  wire logic          ref_clk,
	input  wire logic          rst,
	// wideband data highway
	input  wire logic          wb_valid,
	input  wire logic [63:0]   wb_data,
	// sub-band re-quantized stream
	input  wire sss_sb_t       sb_in,
	// register port
	input  wire logic [7:0]    reg_addr,
	input  wire logic [31:0]   reg_wdata,
	input  wire logic          reg_wr,
	input  wire logic          reg_rd,
	output logic [31:0]        reg_rdata,
	// interval marker
	output logic               interval_tick
);
	localparam int unsigned IW = $clog2(INTERVAL);
	localparam int unsigned RW = $clog2(RING);
	localparam logic [IW-1:0] I_LAST = IW'(INTERVAL - 1);
	localparam logic [IW-1:0] I_WIN  = IW'(INTERVAL / WINDOW_DIV);

	function automatic logic [3:0] nib(input logic [63:0] d, input logic [3:0] i);
		nib = d[{i, 2'b00} +: 4];
	endfunction

	sss_cfg_t          cfg_reg;
	sss_cfg_t          shadow_reg;
	logic [31:0]       pfreq_reg;
	logic [31:0]       pdly_reg;
	logic [6:0]        sb_state_reg;
	logic [6:0]        sb_state_next;
	logic [IW-1:0]     icnt_reg;
	logic [15:0]       nint_reg;
	logic [CW-1:0]     wb_cnt   [N_STREAMS];
	logic [CW-1:0]     wb_lat   [N_STREAMS];
	logic [CW-1:0]     wb8_cnt;
	logic [CW-1:0]     wb8_lat;
	logic [CW-1:0]     sb_cnt;
	logic [CW-1:0]     sb_lat;
	logic [47:0]       pwr_acc;
	logic [47:0]       pwr_lat;
	logic [CW-1:0]     pci_lat;
	logic [CW-1:0]     pcq_lat;
	logic signed [CW-1:0] pc_i;
	logic signed [CW-1:0] pc_q;
	logic [3:0]        hi_reg;
	logic              samp_ok;
	logic signed [7:0] samp;
	logic [6:0]        samp_code;
	logic [3:0]        ring     [RING];
	logic [RW-1:0]     wp_reg;
	logic [3:0]        taps     [N_LAGS];
	logic signed [CW-1:0] acf_acc [N_LAGS];
	logic [CW-1:0]     acf_lat  [N_LAGS];
	logic [3:0]        acf_x;
	logic [3:0]        acf_d;
	logic              acf_win;
	logic [7:0]        wb_byte;
	logic              hit8;
	logic              hitsb;
	logic [47:0]       sq;

	assign interval_tick = (icnt_reg == I_LAST);
	assign acf_win       = (icnt_reg < I_WIN) && wb_valid;
	assign wb_byte       = wb_data[{cfg_reg.wb_lane, 3'b000} +: 8];
	assign acf_x         = nib(wb_data, {2'b00, cfg_reg.acf_prod});
	assign acf_d = (cfg_reg.acf_block == '0) ? acf_x
		: ring[wp_reg - RW'({cfg_reg.acf_block, 6'h00})];
	assign hit8  = wb_valid && cfg_reg.wb_8bit && wb_byte == cfg_reg.wb_state;
	assign hitsb = samp_ok && samp_code == sb_state_reg;
	assign sq    = samp_ok ? 48'(16'(samp * samp)) : '0;

	// interval timer and setting handover
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			icnt_reg <= '0;
			nint_reg <= '0;
		end else if (interval_tick) begin
			icnt_reg <= '0;
			nint_reg <= nint_reg + 16'h0001;
		end else
			icnt_reg <= icnt_reg + IW'(1);
	end

	// new multiplexing settings wait in the shadow until the boundary
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_reg    <= CFG_RST;
			shadow_reg <= CFG_RST;
			pfreq_reg  <= '0;
			pdly_reg   <= '0;
		end else begin
			if (interval_tick)
				cfg_reg <= shadow_reg;
			if (reg_wr) begin
				unique case (reg_addr)
					A_CTRL: begin
						shadow_reg.wb_8bit <= reg_wdata[0];
						shadow_reg.sb_7bit <= reg_wdata[1];
						shadow_reg.sb_step <= reg_wdata[2];
					end
					A_WBSEL: begin
						shadow_reg.wb_base  <= reg_wdata[3:0];
						shadow_reg.wb_lane  <= reg_wdata[6:4];
						shadow_reg.wb_state <= reg_wdata[15:8];
					end
					A_ACFSEL: begin
						shadow_reg.acf_prod  <= reg_wdata[1:0];
						shadow_reg.acf_block <= reg_wdata[7:4];
					end
					A_PFREQ: pfreq_reg <= reg_wdata;
					A_PDLY:  pdly_reg  <= reg_wdata;
					default: ;
				endcase
			end
		end
	end

	// sub-band state: software pick, or automatic stepping per interval
	always_comb begin
		sb_state_next = sb_state_reg;
		if (reg_wr && reg_addr == A_SBST)
			sb_state_next = reg_wdata[6:0];
		else if (interval_tick && cfg_reg.sb_step) begin
			if (sb_state_reg >= (cfg_reg.sb_7bit ? SB7_LAST : SB4_LAST))
				sb_state_next = '0;
			else
				sb_state_next = sb_state_reg + 7'h01;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			sb_state_reg <= '0;
		else
			sb_state_reg <= sb_state_next;
	end

	// 7-bit samples: three high bits on the first beat, four low on the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			hi_reg <= '0;
		else if (sb_in.valid && sb_in.first)
			hi_reg <= sb_in.data;
	end

	always_comb begin
		samp_ok   = sb_in.valid && (!cfg_reg.sb_7bit || !sb_in.first);
		samp_code = cfg_reg.sb_7bit ? {hi_reg[2:0], sb_in.data} : {3'b000, sb_in.data};
		samp      = cfg_reg.sb_7bit ? 8'(signed'(samp_code))
			: 8'(signed'(sb_in.data));
	end

	// wideband counters; a hit in the boundary cycle seeds the next interval
	genvar g;
	generate
		for (g = 0; g < N_STREAMS; g++) begin : g_wb
			logic hit;
			assign hit = wb_valid && !cfg_reg.wb_8bit
				&& nib(wb_data, cfg_reg.wb_base) == 4'(g);
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					wb_cnt[g] <= '0;
					wb_lat[g] <= '0;
				end else if (interval_tick) begin
					wb_lat[g] <= wb_cnt[g];
					wb_cnt[g] <= CW'(hit);
				end else
					wb_cnt[g] <= wb_cnt[g] + CW'(hit);
			end
		end
	endgenerate

	// 8-bit single accumulator, sub-band state counter, total power
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			wb8_cnt <= '0;
			wb8_lat <= '0;
			sb_cnt  <= '0;
			sb_lat  <= '0;
			pwr_acc <= '0;
			pwr_lat <= '0;
		end else begin
			if (interval_tick) begin
				wb8_lat <= wb8_cnt;
				sb_lat  <= sb_cnt;
				pwr_lat <= pwr_acc;
				wb8_cnt <= CW'(hit8);
				sb_cnt  <= CW'(hitsb);
				pwr_acc <= sq;
			end else begin
				wb8_cnt <= wb8_cnt + CW'(hit8);
				sb_cnt  <= sb_cnt + CW'(hitsb);
				pwr_acc <= pwr_acc + sq;
			end
		end
	end

	sss_pcal u_pcal (
		.ref_clk     (ref_clk),
		.rst         (rst),
		.valid       (samp_ok),
		.sample      (samp),
		.restart     (interval_tick),
		.freq        (pfreq_reg),
		.delay_phase (pdly_reg),
		.acc_i       (pc_i),
		.acc_q       (pc_q)
	);

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pci_lat <= '0;
			pcq_lat <= '0;
		end else if (interval_tick) begin
			pci_lat <= pc_i;
			pcq_lat <= pc_q;
		end
	end

	// delay ring reaches lag blocks beyond the 64-tap line, 1024 lags total
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			wp_reg <= '0;
		else if (wb_valid)
			wp_reg <= wp_reg + RW'(1);
	end

	always_ff @(posedge ref_clk) begin
		if (wb_valid)
			ring[wp_reg] <= acf_x;
	end

	generate
		for (g = 0; g < N_LAGS; g++) begin : g_acf
			logic signed [CW-1:0] prod;
			assign prod = acf_win ? CW'($signed(acf_x) * $signed(taps[g])) : '0;
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst)
					taps[g] <= '0;
				else if (wb_valid)
					taps[g] <= (g == 0) ? acf_d : taps[(g == 0) ? 0 : g - 1];
			end
			always_ff @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					acf_acc[g] <= '0;
					acf_lat[g] <= '0;
				end else if (interval_tick) begin
					acf_lat[g] <= acf_acc[g];
					acf_acc[g] <= '0;
				end else
					acf_acc[g] <= acf_acc[g] + prod;
			end
		end
	endgenerate

	// read port: data stand the cycle after the strobe, unmapped reads zero
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst)
			reg_rdata <= '0;
		else if (reg_rd) begin
			if (reg_addr[7:6] == A_ACF[7:6])
				reg_rdata <= acf_lat[reg_addr[5:0]];
			else if (reg_addr[7:4] == A_WBCNT[7:4])
				reg_rdata <= wb_lat[reg_addr[3:0]];
			else begin
				unique case (reg_addr)
					A_CTRL:   reg_rdata <= {29'h0, shadow_reg.sb_step,
						shadow_reg.sb_7bit, shadow_reg.wb_8bit};
					A_WBSEL:  reg_rdata <= {16'h0, shadow_reg.wb_state, 1'b0,
						shadow_reg.wb_lane, shadow_reg.wb_base};
					A_SBST:   reg_rdata <= {25'h0, sb_state_reg};
					A_PFREQ:  reg_rdata <= pfreq_reg;
					A_PDLY:   reg_rdata <= pdly_reg;
					A_ACFSEL: reg_rdata <= {24'h0, shadow_reg.acf_block, 2'b00,
						shadow_reg.acf_prod};
					A_STAT:   reg_rdata <= {nint_reg, 16'h0};
					A_WB8:    reg_rdata <= wb8_lat;
					A_SBCNT:  reg_rdata <= sb_lat;
					A_PWRLO:  reg_rdata <= pwr_lat[31:0];
					A_PWRHI:  reg_rdata <= {16'h0, pwr_lat[47:32]};
					A_PCI:    reg_rdata <= pci_lat;
					A_PCQ:    reg_rdata <= pcq_lat;
					default:  reg_rdata <= '0;
				endcase
			end
		end else
			reg_rdata <= '0;
	end
endmodule : sss_top
`default_nettype wire

// *** tb/sss_chk.sv ***
// Purpose: port checks for sss_top
// Assumes: INTERVAL matches the instance
// Notes: hold checks skip reads that touch a tick cycle
`timescale 1ns/100ps
`default_nettype none
module sss_chk
	import sss_pkg::*;
#(
	parameter int unsigned INTERVAL = 64
)(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst,
	// register port
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	// interval marker
	input wire logic        interval_tick
);
	logic [31:0] cyc_reg;
	logic [15:0] tk_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) cyc_reg <= '0;
		else cyc_reg <= (cyc_reg == INTERVAL - 1) ? '0 : cyc_reg + 32'h1;
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) tk_reg <= '0;
		else if (interval_tick) tk_reg <= tk_reg + 16'h1;
	end
	property p_hold(logic [7:0] a);
		reg_rd && reg_addr == a && !interval_tick ##1 !interval_tick
		##1 reg_rd && reg_addr == a && !interval_tick |=> reg_rdata == $past(reg_rdata, 2);
	endproperty
	a_tick_period: assert property (interval_tick == (cyc_reg == INTERVAL - 1))
		else $error("tick off period");
	a_tick_single: assert property (interval_tick |=> !interval_tick)
		else $error("tick too long");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
		else $error("rdata without read");
	a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h07 |=> reg_rdata == '0)
		else $error("unmapped read not zero");
	a_ctrl_back: assert property (
		reg_wr && reg_addr == A_CTRL ##2 reg_rd && reg_addr == A_CTRL
		|=> reg_rdata[2:0] == $past(reg_wdata[2:0], 3)) else $error("ctrl readback");
	a_pfreq_back: assert property (
		reg_wr && reg_addr == A_PFREQ ##2 reg_rd && reg_addr == A_PFREQ
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("pfreq readback");
	a_stat_count: assert property (
		reg_rd && reg_addr == A_STAT |=> reg_rdata[31:16] == $past(tk_reg))
		else $error("interval count");
	a_sb_hold: assert property (p_hold(A_SBCNT))
		else $error("sub-band snapshot moved");
	a_pwr_hold: assert property (p_hold(A_PWRLO))
		else $error("power snapshot moved");
	c_tick: cover property (interval_tick);
	c_sb: cover property (reg_rd && reg_addr == A_SBCNT);
	c_wb8: cover property (reg_wr && reg_addr == A_CTRL && reg_wdata[0]);
endmodule : sss_chk
bind sss_top sss_chk #(.INTERVAL(INTERVAL)) i_chk (.ref_clk(ref_clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .interval_tick(interval_tick));
`default_nettype wire

// *** tb/sss_far.sv ***
// Purpose: highway and sub-band stream source model
// Assumes: bench picks the pattern
// Notes: always valid, so every count is a whole interval except 7-bit sub-band, which gets a sample every other cycle
`timescale 1ns/100ps
`default_nettype none
module sss_far
	import sss_pkg::*;
(
	// clock and reset
	input wire logic  ref_clk,
	input wire logic  rst,
	// pattern
	input wire logic [3:0] pat,
	input wire logic [6:0] sb_val,
	input wire logic  sb7,
	// streams
	output logic        wb_valid,
	output logic [63:0] wb_data,
	output sss_sb_t     sb_in
);
	logic ph_reg;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ph_reg <= 1'b0;
			wb_valid <= 1'b0;
			wb_data <= {16{4'hA}};
			sb_in <= '0;
		end else begin
			ph_reg <= sb7 & ~ph_reg;
			wb_valid <= 1'b1;
			// stream i carries pat+i
			for (int i = 0; i < 16; i++) wb_data[4*i +: 4] <= pat + 4'(i);
			sb_in.valid <= 1'b1;
			sb_in.first <= sb7 & ~ph_reg;
			sb_in.data <= (sb7 & ~ph_reg) ? {1'b0, sb_val[6:4]} : sb_val[3:0];
		end
	end
endmodule : sss_far
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking bench for sss_top
// Assumes: interval shortened to 64 cycles
// Notes: results wait three ticks, so one whole interval runs on new settings
`timescale 1ns/100ps
`default_nettype none
module testbench
	import sss_pkg::*;
;
	localparam int unsigned IV = 64;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata, d;
	logic        interval_tick, wb_valid;
	logic        sb7 = 1'b0;
	logic [63:0] wb_data;
	logic [3:0]  pat = 4'h3;
	logic [6:0]  sb_val = 7'h00;
	sss_sb_t     sb_in;
	int          n_fail = 0, tests_run = 0, n_tk = 0;
	always #4 ref_clk = ~ref_clk;
	always @(posedge ref_clk) if (!rst && interval_tick) n_tk++;
	sss_far i_far (.ref_clk(ref_clk), .rst(rst), .pat(pat), .sb_val(sb_val), .sb7(sb7),
		.wb_valid(wb_valid), .wb_data(wb_data), .sb_in(sb_in));
	sss_top #(.INTERVAL(IV), .RING(1024)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.wb_valid(wb_valid), .wb_data(wb_data), .sb_in(sb_in), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.interval_tick(interval_tick));
	task automatic end_sim();
		$display("checks %0d fail %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : end_sim
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rdc(string n, logic [7:0] a, logic [31:0] e, logic [31:0] m = '1);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		chk(n, e, d & m);
		@(posedge ref_clk);
	endtask : rdc
	task automatic wt(input int n);
		repeat (n) begin
			#1;
			while (interval_tick !== 1'b1) @(posedge ref_clk) #1;
			@(posedge ref_clk);
		end
	endtask : wt
	task automatic t_stat();
		rdc("stat", A_STAT, 32'(n_tk) << 16, 32'hFFFF0000);
	endtask : t_stat
	task automatic t_regs();
		wr(A_PFREQ, 32'h1234ABCD);
		rdc("pfreq", A_PFREQ, 32'h1234ABCD);
		wr(A_CTRL, 32'h5);
		rdc("ctrl", A_CTRL, 32'h5);
		rdc("unmapped", 8'h07, 32'h0);
		wr(A_CTRL, 32'h0);
	endtask : t_regs
	task automatic t_wb4();
		// the picked stream moves between intervals
		for (int b = 0; b < 16; b += 9) begin
			wr(A_WBSEL, 32'(b));
			wt(3);
			for (int i = 0; i < 16; i++) begin
				rdc("wbcnt", A_WBCNT + 8'(i), (4'(i) == pat + 4'(b)) ? IV : 0);
			end
		end
	endtask : t_wb4
	task automatic t_wb8();
		// lane 2 carries {pat+5, pat+4}, that is 8'h87
		wr(A_CTRL, 32'h1);
		wr(A_WBSEL, 32'h8720);
		wt(3);
		rdc("wb8hit", A_WB8, IV);
		rdc("wb8off", A_WBCNT + 8'h03, 32'h0);
		wr(A_WBSEL, 32'h8820);
		wt(3);
		rdc("wb8miss", A_WB8, 32'h0);
		wr(A_CTRL, 32'h0);
	endtask : t_wb8
	task automatic t_sb();
		sb_val <= 7'h0A;
		wr(A_SBST, 32'h0A);
		wt(3);
		rdc("sb4", A_SBCNT, IV);
		rdc("sb4", A_SBCNT, IV);
		wr(A_SBST, 32'h0B);
		wt(3);
		rdc("sb4miss", A_SBCNT, 32'h0);
		sb7 <= 1'b1;
		sb_val <= 7'h5A;
		wr(A_CTRL, 32'h2);
		wr(A_SBST, 32'h5A);
		wt(3);
		rdc("sb7", A_SBCNT, IV / 2);
		// auto-step wraps at the 7-bit top state
		wr(A_CTRL, 32'h6);
		wt(1);
		wr(A_SBST, 32'h7E);
		wt(1);
		rdc("sbstep", A_SBST, 32'h7F);
		wt(1);
		rdc("sbwrap", A_SBST, 32'h0);
	endtask : t_sb
	task automatic t_pwr();
		// a unit sample gives one count per sample, whatever the power law
		sb_val <= 7'h01;
		wt(3);
		rdc("pwr7", A_PWRLO, IV / 2);
		sb7 <= 1'b0;
		wr(A_CTRL, 32'h0);
		wt(3);
		rdc("pwr4", A_PWRLO, IV);
		rdc("pwrhi", A_PWRHI, 32'h0);
		// stream 0 carries a steady 3, window is a sixteenth of the interval
		rdc("acf3", A_ACF + 8'h05, (IV / WINDOW_DIV) * 9);
		sb_val <= 7'h00;
		pat <= 4'h0;
		wr(A_ACFSEL, 32'h0);
		wt(3);
		rdc("pwr0", A_PWRLO, 32'h0);
		rdc("pwr0", A_PWRLO, 32'h0);
		rdc("pcal", A_PCI, 32'h0);
		rdc("pcalq", A_PCQ, 32'h0);
		rdc("acf", A_ACF, 32'h0);
		// stream 2 carries a steady 2; lag block 1 needs the last 128 ring entries full of it first
		wr(A_ACFSEL, 32'h12);
		wt(4);
		rdc("acfblk", A_ACF + 8'h05, (IV / WINDOW_DIV) * 4);
	endtask : t_pwr
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_stat();
		t_regs();
		t_wb4();
		t_wb8();
		t_sb();
		t_pwr();
		t_stat();
		end_sim();
	end
	initial begin
		#100000;
		n_fail++;
		end_sim();
	end
endmodule : testbench
`default_nettype wire
